// ---- core/qrbsp_pkg.sv ----
// constants and types shared by the burst sram port
// Notes on behaviour
// - Read and write addresses share one bus, sampled on alternating true-clock rises.
// - Each address holds a burst of four words, 18 or 36 bits wide.
// - Data moves on every rise of true and complementary clock, both ports.
// - Only rising edges of the two input clocks time the datapath; the lock timer runs on rising core-clock edges.
// - Loop-disable pin high: once the loop has locked, first read word comes two cycles after the request.
// - Loop-disable pin low: read data comes with one cycle of latency.
// - A valid flag marks the edges carrying valid read burst words.
// - Free-running echo clock pair is driven aligned with read data.
// - Read and write ports run concurrently without disturbing each other.
// - Read data uses only output pins, write data only input pins.
// - Each port has its own select so devices can share buses.
// - Every synchronous input is registered on an input clock before use.
// - Every data output is launched from an input-clocked output register.
// - Captured write bursts reach the array by self-timed logic, no strobe.
// - Reads of an address with a write pending return the newest data.
package qrbsp_pkg;
    localparam int BURST_LEN = 4;
    localparam int WORD_W_NARROW = 18;
    localparam int WORD_W_WIDE = 36;
    localparam int REF_CLK_MHZ = 125;
    localparam int LOCK_TIME_NS = 20480;
    localparam int LOCK_CYCLES = (LOCK_TIME_NS * REF_CLK_MHZ + 999) / 1000;
    localparam int LOCK_CNT_W = 12;
    localparam logic SLOT_RST = 1'h1;
    localparam logic SLOT_READ = 1'h0;
    localparam logic SLOT_WRITE = 1'h1;

    typedef struct packed {
        logic read_port_select_n;
        logic write_port_select_n;
    } qrbsp_sel_t;

    typedef struct packed {
        logic echo_clock_out;
        logic echo_clock_out_n;
    } qrbsp_echo_t;

    typedef enum logic [1:0] {
        LK_IDLE = 2'h0,
        LK_COUNT = 2'h1,
        LK_DONE = 2'h2
    } qrbsp_lock_t;
endpackage

// ---- core/qrbsp_loop_lock.sv ----
// loop lock timer on the core clock, grants long read latency
`timescale 1ns/1ps
module qrbsp_loop_lock (
    // core clock and reset
    input logic ref_clk,
    input logic rst_b,
    // asynchronous latency strap
    input logic loop_disable_pin,
    // long latency granted
    output logic mode_long
);
    import qrbsp_pkg::*;

    logic pin_s1_r;
    logic pin_s2_r;
    qrbsp_lock_t st_r;
    qrbsp_lock_t st_nxt;
    logic [LOCK_CNT_W-1:0] cnt_r;
    logic [LOCK_CNT_W-1:0] cnt_nxt;
    logic mode_r;
    logic mode_nxt;

    if (LOCK_CYCLES < 1 || LOCK_CYCLES >= (1 << LOCK_CNT_W)) begin : g_bad_lock
        $error("lock count does not fit its counter");
    end

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        case (st_r)
            LK_IDLE: begin
                cnt_nxt = '0;
                if (pin_s2_r) begin
                    st_nxt = LK_COUNT;
                end
            end
            LK_COUNT: begin
                if (!pin_s2_r) begin
                    st_nxt = LK_IDLE;
                end else if (cnt_r == LOCK_CNT_W'(LOCK_CYCLES - 1)) begin
                    st_nxt = LK_DONE;
                end else begin
                    cnt_nxt = cnt_r + 1'h1;
                end
            end
            LK_DONE: begin
                if (!pin_s2_r) begin
                    st_nxt = LK_IDLE;
                end
            end
            default: begin
                st_nxt = LK_IDLE;
            end
        endcase
        // registered so the level crosses glitch free
        mode_nxt = (st_nxt == LK_DONE);
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_r <= 1'h0;
            pin_s2_r <= 1'h0;
            st_r <= LK_IDLE;
            cnt_r <= '0;
            mode_r <= 1'h0;
        end else begin
            pin_s1_r <= loop_disable_pin;
            pin_s2_r <= pin_s1_r;
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            mode_r <= mode_nxt;
        end
    end

    assign mode_long = mode_r;
endmodule

// ---- core/qrbsp_port.sv ----
// device side of the burst sram: capture, array, read launch, echo
`timescale 1ns/1ps
module qrbsp_port #(
    parameter int WORD_W = 18,
    parameter int ADDR_W = 6
) (
    // core clock and reset
    input logic ref_clk,
    input logic rst_b,
    // complementary input clocks from the controller
    input logic k_clk,
    input logic k_clk_n,
    // shared address bus and port selects
    input logic [ADDR_W-1:0] addr,
    input qrbsp_pkg::qrbsp_sel_t port_select_n,
    // write data port
    input logic [WORD_W-1:0] wr_data,
    // latency strap
    input logic loop_disable_pin,
    // read data port
    output logic [WORD_W-1:0] rd_data,
    output logic read_valid_flag,
    output qrbsp_pkg::qrbsp_echo_t echo,
    // loop status on the core clock
    output logic loop_locked
);
    import qrbsp_pkg::*;

    localparam int DEPTH = 1 << ADDR_W;
    typedef logic [BURST_LEN-1:0][WORD_W-1:0] qrbsp_burst_t;
    typedef logic [1:0][WORD_W-1:0] qrbsp_pair_t;

    if (WORD_W != WORD_W_NARROW && WORD_W != WORD_W_WIDE) begin : g_bad_w
        $error("word width must be 18 or 36");
    end
    if (ADDR_W < 1 || ADDR_W > 10) begin : g_bad_a
        $error("address width must be 1 to 10");
    end

    function automatic logic hit(input logic v, input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] b);
        return v && (a == b);
    endfunction

    // core clock side: loop lock timer
    logic mode_long_ref;

    qrbsp_loop_lock u_lock (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .loop_disable_pin(loop_disable_pin),
        .mode_long(mode_long_ref)
    );

    assign loop_locked = mode_long_ref;

    // true clock domain state
    logic ml_s1_r;
    logic ml_s2_r;
    logic [ADDR_W-1:0] in_addr_r;
    qrbsp_sel_t in_sel_r;
    logic [WORD_W-1:0] in_wd_r;
    logic slot_r;
    logic slot_nxt;
    logic tk_r;
    logic tk_nxt;
    logic ws_v_r;
    logic ws_v_nxt;
    logic [ADDR_W-1:0] ws_a_r;
    logic [ADDR_W-1:0] ws_a_nxt;
    qrbsp_pair_t ws_d01_r;
    qrbsp_pair_t ws_d01_nxt;
    logic pend_v_r;
    logic pend_v_nxt;
    logic [ADDR_W-1:0] pend_a_r;
    logic [ADDR_W-1:0] pend_a_nxt;
    qrbsp_burst_t pend_d_r;
    qrbsp_burst_t pend_d_nxt;
    qrbsp_burst_t hold_r;
    qrbsp_burst_t hold_nxt;
    logic p1_r;
    logic p1_nxt;
    logic p2_r;
    logic p2_nxt;
    logic [WORD_W-1:0] q_k_r;
    logic [WORD_W-1:0] q_k_nxt;
    logic vk_r;
    logic vk_nxt;
    logic [WORD_W-1:0] qn_pend_r;
    logic [WORD_W-1:0] qn_pend_nxt;
    logic vn_pend_r;
    logic vn_pend_nxt;
    qrbsp_burst_t mem_r [DEPTH];

    // complementary clock domain state
    logic [WORD_W-1:0] in_wdn_r;
    logic [WORD_W-1:0] q_n_r;
    logic vn_r;
    logic tn_r;
    logic tn_nxt;

    logic rd_new;
    logic wr_new;
    logic phase;
    qrbsp_burst_t ws_full_c;
    qrbsp_burst_t rd_words_c;

    // read slot and write slot alternate on the true clock
    assign rd_new = (slot_r == SLOT_READ) && !in_sel_r.read_port_select_n;
    assign wr_new = (slot_r == SLOT_WRITE) && !in_sel_r.write_port_select_n;
    assign ws_full_c = {in_wdn_r, in_wd_r, ws_d01_r};

    // array read with forwarding from writes not yet in the array
    always_comb begin
        rd_words_c = mem_r[in_addr_r];
        if (hit(pend_v_r, pend_a_r, in_addr_r)) begin
            rd_words_c = pend_d_r;
        end
        if (hit(ws_v_r, ws_a_r, in_addr_r)) begin
            rd_words_c = ws_full_c;
        end
    end

    always_comb begin
        slot_nxt = ~slot_r;
        tk_nxt = ~tk_r;
        // write: words 0,1 now, words 2,3 one cycle later
        ws_v_nxt = wr_new;
        ws_a_nxt = wr_new ? in_addr_r : ws_a_r;
        ws_d01_nxt = wr_new ? qrbsp_pair_t'({in_wdn_r, in_wd_r}) : ws_d01_r;
        pend_v_nxt = ws_v_r;
        pend_a_nxt = ws_v_r ? ws_a_r : pend_a_r;
        pend_d_nxt = ws_v_r ? ws_full_c : pend_d_r;
        // read launch, independent of the write path
        hold_nxt = rd_new ? rd_words_c : hold_r;
        p1_nxt = rd_new;
        p2_nxt = p1_r;
        q_k_nxt = q_k_r;
        qn_pend_nxt = qn_pend_r;
        vk_nxt = 1'h0;
        vn_pend_nxt = 1'h0;
        if (!ml_s2_r) begin
            if (rd_new) begin
                q_k_nxt = rd_words_c[0];
                qn_pend_nxt = rd_words_c[1];
                vk_nxt = 1'h1;
                vn_pend_nxt = 1'h1;
            end else if (p1_r) begin
                q_k_nxt = hold_r[2];
                qn_pend_nxt = hold_r[3];
                vk_nxt = 1'h1;
                vn_pend_nxt = 1'h1;
            end
        end else begin
            if (p1_r) begin
                q_k_nxt = hold_r[0];
                qn_pend_nxt = hold_r[1];
                vk_nxt = 1'h1;
                vn_pend_nxt = 1'h1;
            end else if (p2_r) begin
                q_k_nxt = hold_r[2];
                qn_pend_nxt = hold_r[3];
                vk_nxt = 1'h1;
                vn_pend_nxt = 1'h1;
            end
        end
    end

    // rising edges only, input and output registers on the true clock
    always_ff @(posedge k_clk or negedge rst_b) begin
        if (!rst_b) begin
            ml_s1_r <= 1'h0;
            ml_s2_r <= 1'h0;
            in_addr_r <= '0;
            in_sel_r <= '1;
            in_wd_r <= '0;
            slot_r <= SLOT_RST;
            tk_r <= 1'h0;
            ws_v_r <= 1'h0;
            ws_a_r <= '0;
            ws_d01_r <= '0;
            pend_v_r <= 1'h0;
            pend_a_r <= '0;
            pend_d_r <= '0;
            hold_r <= '0;
            p1_r <= 1'h0;
            p2_r <= 1'h0;
            q_k_r <= '0;
            vk_r <= 1'h0;
            qn_pend_r <= '0;
            vn_pend_r <= 1'h0;
        end else begin
            ml_s1_r <= mode_long_ref;
            ml_s2_r <= ml_s1_r;
            in_addr_r <= addr;
            in_sel_r <= port_select_n;
            in_wd_r <= wr_data;
            slot_r <= slot_nxt;
            tk_r <= tk_nxt;
            ws_v_r <= ws_v_nxt;
            ws_a_r <= ws_a_nxt;
            ws_d01_r <= ws_d01_nxt;
            pend_v_r <= pend_v_nxt;
            pend_a_r <= pend_a_nxt;
            pend_d_r <= pend_d_nxt;
            hold_r <= hold_nxt;
            p1_r <= p1_nxt;
            p2_r <= p2_nxt;
            q_k_r <= q_k_nxt;
            vk_r <= vk_nxt;
            qn_pend_r <= qn_pend_nxt;
            vn_pend_r <= vn_pend_nxt;
        end
    end

    // self-timed commit of a completed burst, one row per index
    for (genvar i = 0; i < DEPTH; i++) begin : g_row
        logic row_we;
        assign row_we = pend_v_r && (pend_a_r == ADDR_W'(i));
        always_ff @(posedge k_clk) begin
            if (row_we) begin
                mem_r[i] <= pend_d_r;
            end
        end
    end

    // follows the true clock, so the phase cannot invert
    assign tn_nxt = tk_r;

    always_ff @(posedge k_clk_n or negedge rst_b) begin
        if (!rst_b) begin
            in_wdn_r <= '0;
            q_n_r <= '0;
            vn_r <= 1'h0;
            tn_r <= 1'h0;
        end else begin
            in_wdn_r <= wr_data;
            q_n_r <= qn_pend_r;
            vn_r <= vn_pend_r;
            tn_r <= tn_nxt;
        end
    end

    // high after a true rise, low after a complementary rise
    assign phase = tk_r ^ tn_r;
    assign rd_data = phase ? q_k_r : q_n_r;
    assign read_valid_flag = phase ? vk_r : vn_r;
    assign echo.echo_clock_out = phase;
    assign echo.echo_clock_out_n = ~phase;

    default clocking cb_k @(posedge k_clk);
    endclocking
    default disable iff (!rst_b);

    chk_slot_alternate: assert property (
        1'h1 |=> slot_r != $past(slot_r))
        else $error("address slot did not alternate");
    chk_write_gather: assert property (
        wr_new |=> ##1 (pend_v_r && pend_d_r[0] == $past(in_wd_r, 2)
            && pend_d_r[2] == $past(in_wd_r)))
        else $error("write burst gathered wrongly");
    chk_self_write: assert property (
        pend_v_r |=> mem_r[$past(pend_a_r)] == $past(pend_d_r))
        else $error("pending burst not written to array");
    chk_coherent_new: assert property (
        rd_new && hit(ws_v_r, ws_a_r, in_addr_r) |=> hold_r == $past(ws_full_c))
        else $error("read missed write in flight");
    chk_coherent_pend: assert property (
        rd_new && $past(pend_v_r) && in_addr_r == $past(pend_a_r)
            && !hit(ws_v_r, ws_a_r, in_addr_r)
            |=> hold_r == $past(pend_d_r, 2))
        else $error("read missed just committed write");
    chk_short_lat: assert property (
        rd_new && !ml_s2_r |=> (vk_r && q_k_r == $past(rd_words_c[0]))
            ##1 (vk_r && q_k_r == hold_r[2]))
        else $error("one cycle read latency broken");
    chk_long_lat: assert property (
        rd_new && ml_s2_r |=> ##1 (vk_r && q_k_r == $past(rd_words_c[0], 2)))
        else $error("two cycle read latency broken");
    chk_odd_word: assert property (
        rd_new && !ml_s2_r |=> vn_pend_r && qn_pend_r == $past(rd_words_c[1]))
        else $error("odd read word not queued");
    chk_valid_quiet: assert property (
        !rd_new && !p1_r && !p2_r |=> !vk_r && !vn_pend_r)
        else $error("valid without a selected read");
    chk_echo_run: assert property (
        1'h1 |=> tk_r != $past(tk_r))
        else $error("echo source stopped");
endmodule

// ---- sim/qrbsp_ctrl_model.sv ----
// controller model: input clocks, slot schedule, write data, expected reads
`timescale 1ns/1ps
module qrbsp_ctrl_model #(
    parameter int WORD_W = 18,
    parameter int ADDR_W = 4
) (
    // reset from the bench
    input wire logic rst_b,
    // complementary input clocks
    output logic k_clk,
    output logic k_clk_n,
    // address, selects and write data
    output logic [ADDR_W-1:0] addr,
    output qrbsp_pkg::qrbsp_sel_t port_select_n,
    output logic [WORD_W-1:0] wr_data
);
    import qrbsp_pkg::*;
    int seed = 32'h64d930e0;
    int lat = 1;
    int kcnt = 0;
    bit nxt_rd = 1'b1;
    int rq[$];
    int wa[$];
    logic [4*WORD_W-1:0] wd[$];
    logic [WORD_W-1:0] dq[$];
    logic [4*WORD_W-1:0] mem [2**ADDR_W];
    int edue[$];
    logic [WORD_W-1:0] edat[$];

    function automatic int rnd();
        return $random(seed);
    endfunction

    task automatic wr(input int a, input logic [4*WORD_W-1:0] d);
        wa.push_back(a);
        wd.push_back(d);
    endtask

    task automatic rd(input int a);
        rq.push_back(a);
    endtask

    initial begin
        addr = '0;
        port_select_n = 2'h3;
        wr_data = '0;
        k_clk = 1'b0;
        #5.3;
        forever #32 k_clk = ~k_clk;
    end
    assign k_clk_n = ~k_clk;

    // everything changes just after a rising edge of either clock
    always @(posedge k_clk or posedge k_clk_n) begin
        int a;
        logic [4*WORD_W-1:0] d;
        logic [ADDR_W-1:0] ad;
        if (!rst_b) begin
            nxt_rd <= 1'b1;
            kcnt <= 0;
            port_select_n <= 2'h3;
            dq.delete();
        end else if (k_clk) begin
            kcnt <= kcnt + 1;
            nxt_rd <= !nxt_rd;
            ad = ADDR_W'(rnd());
            wr_data <= dq.size() != 0 ? dq.pop_front() : ~wr_data;
            if (nxt_rd) begin
                // off-slot select is noise the device must ignore
                port_select_n.read_port_select_n <= 1'(rnd());
                a = -1;
                if (wa.size() != 0) begin
                    a = wa.pop_front();
                    d = wd.pop_front();
                end
                port_select_n.write_port_select_n <= (a < 0);
                if (a >= 0) begin
                    ad = ADDR_W'(a);
                    mem[a] = d;
                    // word 0 leaves at the next complementary rise
                    for (int i = 0; i < BURST_LEN; i++) begin
                        dq.push_back(d[i*WORD_W +: WORD_W]);
                    end
                end
            end else begin
                port_select_n.write_port_select_n <= 1'(rnd());
                a = rq.size() != 0 ? rq.pop_front() : -1;
                port_select_n.read_port_select_n <= (a < 0);
                if (a >= 0) begin
                    ad = ADDR_W'(a);
                    for (int i = 0; i < BURST_LEN; i++) begin
                        edue.push_back(2 * (kcnt + 1 + lat) + i);
                        edat.push_back(mem[a][i*WORD_W +: WORD_W]);
                    end
                end
            end
            addr <= ad;
        end else begin
            wr_data <= dq.size() != 0 ? dq.pop_front() : ~wr_data;
        end
    end
endmodule

// ---- sim/quad_rate_burst_sram_port_test.sv ----
// testbench of the burst sram port against the controller model
`timescale 1ns/1ps
module quad_rate_burst_sram_port_test;
    import qrbsp_pkg::*;
    localparam int W = 18;
    localparam int AW = 4;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic loop_disable_pin = 1'b0;
    logic k_clk;
    logic k_clk_n;
    logic [AW-1:0] addr;
    qrbsp_sel_t port_select_n;
    logic [W-1:0] wr_data;
    logic [W-1:0] rd_data;
    logic read_valid_flag;
    qrbsp_echo_t echo;
    logic loop_locked;
    int errors = 0;
    int n_compared = 0;
    int rc = 0;
    int t0;

    qrbsp_ctrl_model #(.WORD_W(W), .ADDR_W(AW)) ctrl_i (
        .rst_b(rst_b), .k_clk(k_clk), .k_clk_n(k_clk_n), .addr(addr),
        .port_select_n(port_select_n), .wr_data(wr_data));

    qrbsp_port #(.WORD_W(W), .ADDR_W(AW)) qrbsp_port_i (
        .ref_clk(ref_clk), .rst_b(rst_b), .k_clk(k_clk), .k_clk_n(k_clk_n),
        .addr(addr), .port_select_n(port_select_n), .wr_data(wr_data),
        .loop_disable_pin(loop_disable_pin), .rd_data(rd_data),
        .read_valid_flag(read_valid_flag), .echo(echo),
        .loop_locked(loop_locked));

    initial begin
        forever #4 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) rc <= rc + 1;

    task automatic miss(input string m);
        errors++;
        $display("MISMATCH at %0t: %s", $time, m);
    endtask

    task automatic test_done;
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // random bursts, idle slots, reads often aimed at the fresh write
    task automatic traffic(input int n);
        int a;
        int b;
        for (int i = 0; i < n; i++) begin
            a = ctrl_i.rnd() & (2**AW - 1);
            if ((ctrl_i.rnd() & 7) == 0) a = -1;
            ctrl_i.wr(a, (4*W)'({ctrl_i.rnd(), ctrl_i.rnd(), ctrl_i.rnd()}));
            b = ctrl_i.rnd() & (2**AW - 1);
            if ((ctrl_i.rnd() & 7) == 0) b = -1;
            else if ((ctrl_i.rnd() & 1) != 0) b = a;
            ctrl_i.rd(b);
        end
        for (int i = 0; i < 2000; i++) begin
            if (ctrl_i.rq.size() + ctrl_i.wa.size() + ctrl_i.edue.size() == 0)
                break;
            @(posedge k_clk);
        end
        n_compared++;
        if (ctrl_i.edue.size() != 0 || ctrl_i.rq.size() != 0) begin
            miss("read bursts never completed");
        end
    endtask

    // watches every rising edge of either input clock
    always @(posedge k_clk or posedge k_clk_n) begin
        int cur;
        bit due;
        bit vexp;
        logic [W-1:0] want;
        #2;
        if (rst_b) begin
            cur = 2 * (ctrl_i.kcnt - 1) + (k_clk ? 0 : 1);
            due = ctrl_i.edue.size() != 0 && ctrl_i.edue[0] <= cur;
            vexp = due && ctrl_i.edue[0] == cur;
            n_compared++;
            if (read_valid_flag !== vexp) begin
                miss("read valid flag wrong on this edge");
            end
            n_compared++;
            if (echo !== (k_clk ? 2'h2 : 2'h1)) begin
                miss("echo clocks out of step with data");
            end
            if (due) begin
                void'(ctrl_i.edue.pop_front());
                want = ctrl_i.edat.pop_front();
                n_compared++;
                if (rd_data !== want) begin
                    miss("read burst word differs");
                end
            end
        end
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        repeat (2) @(posedge k_clk);
        @(posedge ref_clk);
        rst_b <= 1'b1;
        for (int a = 0; a < 2**AW; a++) begin
            ctrl_i.wr(a, (4*W)'({ctrl_i.rnd(), ctrl_i.rnd(), ctrl_i.rnd()}));
        end
        traffic(0);
        traffic(40);
        @(posedge ref_clk);
        loop_disable_pin <= 1'b1;
        t0 = rc;
        traffic(30);
        while (loop_locked !== 1'b1 && rc - t0 < 4000) @(posedge ref_clk);
        n_compared++;
        if (rc - t0 < LOCK_CYCLES || rc - t0 > LOCK_CYCLES + 8) begin
            miss("loop lock time off");
        end
        repeat (3) @(posedge k_clk);
        ctrl_i.lat = 2;
        traffic(40);
        @(posedge ref_clk);
        loop_disable_pin <= 1'b0;
        repeat (6) @(posedge ref_clk);
        n_compared++;
        if (loop_locked !== 1'b0) begin
            miss("loop lock not dropped");
        end
        repeat (3) @(posedge k_clk);
        ctrl_i.lat = 1;
        traffic(20);
        test_done;
    end

    initial begin
        #200000;
        errors++;
        test_done;
    end
endmodule
